// ### bench/diag_host_model.sv
`timescale 1ns/1ps
// ====================
// register host
module diag_host_model (
  input  wire logic       clk,     // system clock
  output logic      [7:0] addr,    // byte offset
  output logic            wr,      // write strobe
  output logic      [7:0] wdata,   // write data
  output logic            rd,      // read strobe
  input  wire logic [7:0] rdata,   // read data
  input  wire logic       rvalid   // read data valid
);
  initial
  begin
    addr  = 8'h00;
    wr    = 1'b0;
    wdata = 8'h00;
    rd    = 1'b0;
  end

  // host may set or clear the soft bits at will
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    // released lines must not keep showing the last value
    addr  <= ~a;
    wdata <= ~d;
  endtask : put

  task automatic get(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
    v = rvalid;
  endtask : get
endmodule : diag_host_model

// ### bench/transceiver_diag_flags_loopback_ctl_tb.sv
`timescale 1ns/1ps
module transceiver_diag_flags_loopback_ctl_tb;
  logic                       clk, rst_n, wr, rd, rvalid, txdis, rxhi, mvalid;
  logic                       txd_pin, rxr_pin, txr_pin, fault, los, nrdy;
  logic [7:0]                 addr, wdata, rdata, w, e, p;
  logic [9:0]                 fa, fw;
  diag_flags_pkg::monitor_s   mon, m;
  diag_flags_pkg::limit_set_t alim, wlim, a, wl;
  diag_flags_pkg::route_s     route;
  int                         bad_count, checked, cycles;
  logic [7:0]                 lbw [10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h0f, 8'h05, 8'h0a, 8'h06, 8'hf0, 8'h00};
  logic [7:0]                 rst_regs [8] = '{8'h6e, 8'h6f, 8'h70, 8'h71, 8'h74, 8'h75, 8'h72, 8'h00};

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // short latency parameter: the real reaction is two edges anyway
  diag_flags_ctl #(.RESP_CYCLES(20)) diag_flags_ctl_inst (
    .CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd),
    .REG_RDATA(rdata), .REG_RVALID(rvalid), .TX_DISABLE_PIN(txd_pin), .RX_RATE_PIN(rxr_pin),
    .TX_RATE_PIN(txr_pin), .TX_FAULT_IN(fault), .RX_LOS_IN(los), .DATA_NRDY(nrdy), .MON_VALID(mvalid),
    .MON(mon), .ALARM_LIM(alim), .WARN_LIM(wlim), .TX_DISABLE(txdis), .RX_RATE_HIGH(rxhi), .ROUTE(route));

  diag_host_model diag_host_model_inst (
    .clk(clk), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd), .rdata(rdata), .rvalid(rvalid));

  // ====================
  // checking
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    checked++;
    if (g !== x)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] ad, input logic [7:0] x);
    logic [7:0] d;
    logic       v;
    diag_host_model_inst.get(ad, d, v);
    chk("read valid", 8'h01, {7'h00, v});
    chk($sformatf("register %h", ad), x, d);
  endtask : rdchk

  // several bits written at once: forward wins over plain wrap
  function automatic logic [7:0] lb(input logic [7:0] v);
    if (v[3]) return 8'h0c;
    if (v[1]) return 8'h03;
    if (v[2]) return 8'h04;
    if (v[0]) return 8'h01;
    return 8'h00;
  endfunction : lb

  // pairs {high, low} per quantity; temperature only is signed
  function automatic logic [9:0] flg(input diag_flags_pkg::monitor_s mv, input diag_flags_pkg::limit_set_t l);
    int         v, h, lo;
    logic [9:0] f;
    for (int i = 0; i < 5; i++)
    begin
      if (i == 4)
      begin
        v  = $signed(mv[79:64]);
        h  = $signed(l[4].hi);
        lo = $signed(l[4].lo);
      end
      else
      begin
        v  = mv[16*i +: 16];
        h  = l[i].hi;
        lo = l[i].lo;
      end
      f[2*i+1] = v > h;
      f[2*i]   = v < lo;
    end
    return f;
  endfunction : flg

  task automatic conclude;
    $display("mismatches %0d comparisons %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      conclude();
    end
  end

  // ====================
  // sequence
  initial
  begin
    rst_n = 1'b0;
    {txd_pin, rxr_pin, txr_pin, fault, los, nrdy, mvalid} = 7'h00;
    mon  = '0;
    alim = '0;
    wlim = '0;
    w    = 8'($urandom(30100));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rst_regs[i]) rdchk(rst_regs[i], 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      w = 8'($urandom);
      p = 8'($urandom);
      @(posedge clk);
      {txd_pin, rxr_pin, txr_pin, fault, los, nrdy} <= p[5:0];
      diag_host_model_inst.put(8'h6e, w);
      // read right behind the write, then the outputs two edges after it
      rdchk(8'h6e, {p[5], w[6], p[3], p[4], w[3], p[2:0]});
      chk("tx disable", {7'h00, w[6] | p[5]}, {7'h00, txdis});
      chk("rx rate", {7'h00, w[3] | p[4]}, {7'h00, rxhi});
    end
    foreach (lbw[i])
    begin
      e = lb(lbw[i]);
      diag_host_model_inst.put(8'h6f, lbw[i]);
      repeat (2) @(posedge clk);
      #1;
      chk("route", {4'h0, e[2], e[3], e[0], e[1]}, {4'h0, route});
      rdchk(8'h6f, e);
    end
    for (int n = 0; n < 24; n++)
    begin
      for (int i = 0; i < 5; i++)
      begin
        m[16*i +: 16] = 16'($urandom);
        a[i]  = $urandom;
        wl[i] = $urandom;
        // equal to a limit must not flag
        if ($urandom % 4 == 0) a[i].hi = m[16*i +: 16];
        if ($urandom % 4 == 0) wl[i].lo = m[16*i +: 16];
      end
      @(posedge clk);
      mon    <= m;
      alim   <= a;
      wlim   <= wl;
      mvalid <= 1'b1;
      @(posedge clk);
      mvalid <= 1'b0;
      mon    <= ~m;
      fa = flg(m, a);
      fw = flg(m, wl);
      diag_host_model_inst.put(8'h71, 8'hff);
      rdchk(8'h70, fa[9:2]);
      rdchk(8'h71, {fa[1:0], 6'h00});
      rdchk(8'h74, fw[9:2]);
      rdchk(8'h75, {fw[1:0], 6'h00});
    end
    // reset in mid-run with a wrap active: everything falls back to off
    diag_host_model_inst.put(8'h6f, 8'h08);
    repeat (2) @(posedge clk);
    #1;
    chk("route before reset", 8'h0c, {4'h0, route});
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("route after reset", 8'h00, {4'h0, route});
    rdchk(8'h6f, 8'h00);
    conclude();
  end
endmodule : transceiver_diag_flags_loopback_ctl_tb

// ### src/diag_flags_cfg.svh
`ifndef DIAG_FLAGS_CFG_SVH
`define DIAG_FLAGS_CFG_SVH

// ==========================================================
// register offsets
`define OFS_SOFT_STATUS   8'h6e
`define OFS_LOOPBACK      8'h6f
`define OFS_ALARM_HI      8'h70
`define OFS_ALARM_LO      8'h71
`define OFS_WARN_HI       8'h74
`define OFS_WARN_LO       8'h75

// ==========================================================
// soft status/control field positions
`define BIT_TXDIS_STATE   7
`define BIT_TXDIS_SOFT    6
`define BIT_TXRATE_STATE  5
`define BIT_RXRATE_STATE  4
`define BIT_RXRATE_SOFT   3
`define BIT_TXFAULT_STATE 2
`define BIT_RXLOS_STATE   1
`define BIT_DATA_NRDY     0

// ==========================================================
// loopback control field positions
`define BIT_OPT_FWD       3
`define BIT_OPT_LOOP      2
`define BIT_ELEC_FWD      1
`define BIT_ELEC_LOOP     0

// ==========================================================
// reset values and timing
`define RST_SOFT_CTL      1'b0
`define RST_LOOPBACK      4'h0
`define RST_FLAGS         10'h000
`define CLK_FREQ_HZ       100000000
`define SOFT_RESP_MS      100
`define SOFT_RESP_CYCLES  ((`SOFT_RESP_MS) * ((`CLK_FREQ_HZ) / 1000))

`endif

// ### src/diag_flags_ctl.sv
`timescale 1ns/1ps
`include "diag_flags_cfg.svh"
// Notes on behaviour
// - soft commands take effect within 100 ms
// - transmitter off if soft bit or pin
// - receiver high rate if soft bit or pin
// - optical loopback wraps rx optical to tx
// - optical forward also feeds rx electrical
// - optical forward sets bit 2, clears others
// - electrical loopback wraps tx electrical, clears others
// - electrical forward also feeds tx optical
// - electrical forward sets bit 0, clears others
// - alarm byte: temperature and supply flags
// - alarm byte: bias and tx power flags
// - rx power alarms, low bits reserved
// - warning byte mirrors alarm byte layout
// - rx power warnings, low bits reserved
// - soft transmit disable is read/write
// - temperature compared as signed 16-bit
module diag_flags_ctl #(
  parameter int RESP_CYCLES = `SOFT_RESP_CYCLES
) (
  input  wire logic                     CLK,          // 100 MHz system clock
  input  wire logic                     RST_N,        // async reset, active low
  input  wire logic [7:0]               REG_ADDR,     // byte offset of access
  input  wire logic                     REG_WR,       // write strobe, one cycle
  input  wire logic [7:0]               REG_WDATA,    // write data
  input  wire logic                     REG_RD,       // read strobe, one cycle
  output logic      [7:0]               REG_RDATA,    // read data, registered
  output logic                          REG_RVALID,   // read data valid pulse
  input  wire logic                     TX_DISABLE_PIN, // transmit disable pin
  input  wire logic                     RX_RATE_PIN,  // receive rate pick pin
  input  wire logic                     TX_RATE_PIN,  // transmit rate pick pin
  input  wire logic                     TX_FAULT_IN,  // transmit fault state
  input  wire logic                     RX_LOS_IN,    // loss of signal state
  input  wire logic                     DATA_NRDY,    // monitor data not ready
  input  wire logic                     MON_VALID,    // new monitor sample
  input  wire diag_flags_pkg::monitor_s MON,          // monitored values
  input  wire diag_flags_pkg::limit_set_t ALARM_LIM,  // alarm thresholds
  input  wire diag_flags_pkg::limit_set_t WARN_LIM,   // warning thresholds
  output logic                          TX_DISABLE,   // transmitter disabled
  output logic                          RX_RATE_HIGH, // receiver high rate
  output diag_flags_pkg::route_s        ROUTE         // loopback path selects
);

  if (RESP_CYCLES < 1)
  begin : g_resp_check
    $error("RESP_CYCLES must be at least one");
  end

  // ==========================================================
  // pin synchronisers
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end
    else
    begin
      sync1_ff <= {TX_DISABLE_PIN, RX_RATE_PIN, TX_RATE_PIN};
      sync2_ff <= sync1_ff;
    end
  end

  wire txdis_pin_s  = sync2_ff[2];
  wire rxrate_pin_s = sync2_ff[1];
  wire txrate_pin_s = sync2_ff[0];

  // ==========================================================
  // register decode
  wire wr_soft  = REG_WR && (REG_ADDR == `OFS_SOFT_STATUS);
  wire wr_loop  = REG_WR && (REG_ADDR == `OFS_LOOPBACK);

  logic       txdis_soft_ff;
  logic       rxrate_soft_ff;
  logic [3:0] loop_ff;

  // forward bits outrank plain wraps, optical outranks electrical
  wire [3:0] nxt_loop =
    REG_WDATA[`BIT_OPT_FWD]   ? 4'hc :
    REG_WDATA[`BIT_ELEC_FWD]  ? 4'h3 :
    REG_WDATA[`BIT_OPT_LOOP]  ? 4'h4 :
    REG_WDATA[`BIT_ELEC_LOOP] ? 4'h1 :
                                4'h0;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      txdis_soft_ff  <= `RST_SOFT_CTL;
      rxrate_soft_ff <= `RST_SOFT_CTL;
      loop_ff        <= `RST_LOOPBACK;
    end
    else
    begin
      if (wr_soft)
      begin
        txdis_soft_ff  <= REG_WDATA[`BIT_TXDIS_SOFT];
        rxrate_soft_ff <= REG_WDATA[`BIT_RXRATE_SOFT];
      end
      if (wr_loop)
        loop_ff <= nxt_loop;
    end
  end

  // ==========================================================
  // effective controls, two cycles after the write strobe well inside the limit
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      TX_DISABLE   <= 1'b0;
      RX_RATE_HIGH <= 1'b0;
      ROUTE        <= '0;
    end
    else
    begin
      TX_DISABLE      <= txdis_soft_ff | txdis_pin_s;
      RX_RATE_HIGH    <= rxrate_soft_ff | rxrate_pin_s;
      ROUTE.opt_loop  <= loop_ff[`BIT_OPT_LOOP];
      ROUTE.opt_fwd   <= loop_ff[`BIT_OPT_LOOP] & loop_ff[`BIT_OPT_FWD];
      ROUTE.elec_loop <= loop_ff[`BIT_ELEC_LOOP];
      ROUTE.elec_fwd  <= loop_ff[`BIT_ELEC_LOOP] & loop_ff[`BIT_ELEC_FWD];
    end
  end

  // ==========================================================
  // threshold comparison, bit 9 is temperature high, bit 0 rx power low
  wire [4:0][15:0] mon_val = MON;
  wire [9:0]       nxt_alarm;
  wire [9:0]       nxt_warn;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_chan
      if (gi == 4)
      begin : g_signed
        // temperature is two's complement in 1/256 degree steps
        assign nxt_alarm[2*gi+1] = $signed(mon_val[gi]) > $signed(ALARM_LIM[gi].hi);
        assign nxt_alarm[2*gi]   = $signed(mon_val[gi]) < $signed(ALARM_LIM[gi].lo);
        assign nxt_warn[2*gi+1]  = $signed(mon_val[gi]) > $signed(WARN_LIM[gi].hi);
        assign nxt_warn[2*gi]    = $signed(mon_val[gi]) < $signed(WARN_LIM[gi].lo);
      end
      else
      begin : g_unsigned
        assign nxt_alarm[2*gi+1] = mon_val[gi] > ALARM_LIM[gi].hi;
        assign nxt_alarm[2*gi]   = mon_val[gi] < ALARM_LIM[gi].lo;
        assign nxt_warn[2*gi+1]  = mon_val[gi] > WARN_LIM[gi].hi;
        assign nxt_warn[2*gi]    = mon_val[gi] < WARN_LIM[gi].lo;
      end
    end
  endgenerate

  logic [9:0] alarm_ff;
  logic [9:0] warn_ff;

  // level flags: no software clear, so no set/clear race exists
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      alarm_ff <= `RST_FLAGS;
      warn_ff  <= `RST_FLAGS;
    end
    else if (MON_VALID)
    begin
      alarm_ff <= nxt_alarm;
      warn_ff  <= nxt_warn;
    end
  end

  // ==========================================================
  // read mux
  wire [7:0] soft_byte = {txdis_pin_s, txdis_soft_ff, txrate_pin_s, rxrate_pin_s,
                          rxrate_soft_ff, TX_FAULT_IN, RX_LOS_IN, DATA_NRDY};
  wire [7:0] alarm_hi_byte = alarm_ff[9:2];
  wire [7:0] alarm_lo_byte = {alarm_ff[1:0], 6'h00};
  wire [7:0] warn_hi_byte  = warn_ff[9:2];
  wire [7:0] warn_lo_byte  = {warn_ff[1:0], 6'h00};

  wire [7:0] rd_mux =
    (REG_ADDR == `OFS_SOFT_STATUS) ? soft_byte :
    (REG_ADDR == `OFS_LOOPBACK)    ? {4'h0, loop_ff} :
    (REG_ADDR == `OFS_ALARM_HI)    ? alarm_hi_byte :
    (REG_ADDR == `OFS_ALARM_LO)    ? alarm_lo_byte :
    (REG_ADDR == `OFS_WARN_HI)     ? warn_hi_byte :
    (REG_ADDR == `OFS_WARN_LO)     ? warn_lo_byte :
                                     8'h00;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end
    else
    begin
      REG_RVALID <= REG_RD;
      if (REG_RD)
        REG_RDATA <= rd_mux;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  property p_soft_txdis_effect;
    wr_soft && REG_WDATA[`BIT_TXDIS_SOFT] |-> ##2 TX_DISABLE;
  endproperty
  a_soft_txdis_effect: assert property (p_soft_txdis_effect) else $error("soft tx disable late");

  property p_txdis_or;
    ##1 TX_DISABLE == ($past(txdis_soft_ff) | $past(txdis_pin_s));
  endproperty
  a_txdis_or: assert property (p_txdis_or) else $error("tx disable not or of sources");

  property p_rxrate_pin;
    rxrate_pin_s |=> RX_RATE_HIGH;
  endproperty
  a_rxrate_pin: assert property (p_rxrate_pin) else $error("rx rate pin ignored");

  property p_opt_fwd_write;
    wr_loop && REG_WDATA[`BIT_OPT_FWD] |=> loop_ff == 4'hc ##1 ROUTE.opt_loop && ROUTE.opt_fwd;
  endproperty
  a_opt_fwd_write: assert property (p_opt_fwd_write) else $error("optical forward write wrong");

  property p_elec_fwd_write;
    wr_loop && !REG_WDATA[`BIT_OPT_FWD] && REG_WDATA[`BIT_ELEC_FWD]
      |=> loop_ff == 4'h3 ##1 ROUTE.elec_loop && ROUTE.elec_fwd && !ROUTE.opt_loop;
  endproperty
  a_elec_fwd_write: assert property (p_elec_fwd_write) else $error("electrical forward write wrong");

  property p_elec_loop_excl;
    wr_loop && REG_WDATA[3:0] == 4'h1 |=> loop_ff == 4'h1;
  endproperty
  a_elec_loop_excl: assert property (p_elec_loop_excl) else $error("electrical wrap not exclusive");

  property p_opt_loop_only;
    wr_loop && REG_WDATA[3:0] == 4'h4 |=> ##1 ROUTE.opt_loop && !ROUTE.opt_fwd && !ROUTE.elec_loop;
  endproperty
  a_opt_loop_only: assert property (p_opt_loop_only) else $error("optical wrap route wrong");

  property p_reserved_zero;
    REG_RVALID && ($past(REG_ADDR) == `OFS_ALARM_LO || $past(REG_ADDR) == `OFS_WARN_LO)
      |-> REG_RDATA[5:0] == 6'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved flag bits nonzero");

  property p_temp_signed;
    MON_VALID && MON.temp[15] && !ALARM_LIM[4].lo[15] |=> alarm_ff[8];
  endproperty
  a_temp_signed: assert property (p_temp_signed) else $error("negative temperature not low");

  property p_flags_hold;
    !MON_VALID |=> $stable(alarm_ff) && $stable(warn_ff);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flags changed without update");

  property p_bias_hi;
    MON_VALID && MON.bias > WARN_LIM[2].hi |=> warn_ff[5];
  endproperty
  a_bias_hi: assert property (p_bias_hi) else $error("bias high warning missed");

  property p_soft_readback;
    wr_soft ##1 !REG_WR ##1 (REG_RD && REG_ADDR == `OFS_SOFT_STATUS)
      |=> REG_RDATA[`BIT_TXDIS_SOFT] == $past(REG_WDATA[`BIT_TXDIS_SOFT], 3);
  endproperty
  a_soft_readback: assert property (p_soft_readback) else $error("soft tx disable readback wrong");

  property p_rxrate_soft_effect;
    wr_soft && REG_WDATA[`BIT_RXRATE_SOFT] |-> ##2 RX_RATE_HIGH;
  endproperty
  a_rxrate_soft_effect: assert property (p_rxrate_soft_effect) else $error("soft rx rate late");

  property p_loop_off;
    wr_loop && REG_WDATA[3:0] == 4'h0 |=> loop_ff == 4'h0 ##1 !ROUTE.opt_loop && !ROUTE.elec_loop;
  endproperty
  a_loop_off: assert property (p_loop_off) else $error("wrap not disabled");

  property p_vcc_inside;
    MON_VALID && MON.vcc <= ALARM_LIM[3].hi && MON.vcc >= ALARM_LIM[3].lo |=> alarm_ff[7:6] == 2'b00;
  endproperty
  a_vcc_inside: assert property (p_vcc_inside) else $error("supply alarm stuck");

  c_opt_fwd: cover property (ROUTE.opt_fwd);
  c_elec_fwd: cover property (ROUTE.elec_fwd);
  c_alarm_any: cover property (MON_VALID ##1 alarm_ff != 10'h000);
  c_rate_soft: cover property (rxrate_soft_ff && !rxrate_pin_s ##1 RX_RATE_HIGH);
  c_rx_alarm: cover property (MON_VALID ##1 alarm_ff[1]);

endmodule : diag_flags_ctl

// ### src/diag_flags_pkg.sv
package diag_flags_pkg;

  // one threshold pair per monitored quantity
  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } limit_s;

  // index 4 temperature, 3 supply, 2 bias, 1 tx power, 0 rx power
  typedef limit_s [4:0] limit_set_t;

  typedef struct packed {
    logic signed [15:0] temp;
    logic        [15:0] vcc;
    logic        [15:0] bias;
    logic        [15:0] tx_pwr;
    logic        [15:0] rx_pwr;
  } monitor_s;

  typedef struct packed {
    logic opt_loop;
    logic opt_fwd;
    logic elec_loop;
    logic elec_fwd;
  } route_s;

endpackage : diag_flags_pkg
